// ---- design/pdr_defines.vh ----
// register offsets, field positions and reset values of the pulse data bank
`ifndef PDR_DEFINES_VH
`define PDR_DEFINES_VH
`define PDR_ADDR_W          4
`define PDR_OFS_OUT_HIGH    4'h0
`define PDR_OFS_OUT_LOW     4'h1
`define PDR_OFS_NXT_HIGH    4'h2
`define PDR_OFS_NXT_HIGH_LO 4'h3
`define PDR_OFS_NXT_LOW     4'h4
`define PDR_OFS_NXT_LOW_LO  4'h5
`define PDR_OFS_EN_HIGH     4'h6
`define PDR_OFS_EN_LOW      4'h7
`define PDR_OFS_TRIG_SEL    4'h8
`define PDR_DATA_RST        8'h00
`define PDR_EN_RST          8'h00
`define PDR_TRIG_SEL_RST    8'hff
`define PDR_NIB_FILL        4'hf
`define PDR_UNMAPPED_RD     8'h00
`define PDR_SEL_G3_HI       7
`define PDR_SEL_G3_LO       6
`define PDR_SEL_G2_HI       5
`define PDR_SEL_G2_LO       4
`define PDR_SEL_G1_HI       3
`define PDR_SEL_G1_LO       2
`define PDR_SEL_G0_HI       1
`define PDR_SEL_G0_LO       0
`endif

// ---- design/pdr_trig_sel.v ----
// picks one of four compare-match events as a group's output trigger
module pdr_trig_sel (
  input  wire [3:0] cmp_match,
  input  wire [1:0] sel,
  output wire       trig
);
  assign trig = cmp_match[sel];
endmodule

// ---- design/pdr_out_byte.v ----
// one output-data byte: trigger transfer under per-bit enables, cpu write
module pdr_out_byte (
  input  wire       clk,
  input  wire       srst,
  input  wire [7:0] enable,
  input  wire [7:0] next_data,
  input  wire       trig_hi,
  input  wire       trig_lo,
  input  wire       wr,
  input  wire [7:0] wdata,
  output reg  [7:0] data_r
);
`include "pdr_defines.vh"
  wire [7:0] data_nxt;

  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      wire trig_b;
      assign trig_b = (i >= 4) ? trig_hi : trig_lo;
      // enabled bits ignore cpu writes and only follow the trigger, while
      // a disabled bit is never loaded from next data
      assign data_nxt[i] = !enable[i] ? (wr ? wdata[i] : data_r[i])
                         : trig_b ? next_data[i]
                         : data_r[i];
    end
  endgenerate

  // one register for the whole byte keeps a single driver per bit
  always @(posedge clk) begin
    if (srst) begin
      data_r <= `PDR_DATA_RST;
    end else begin
      data_r <= data_nxt;
    end
  end
endmodule

// ---- design/pdr_bank.v ----
// pulse output data and next data register bank with cpu port
//
// Implementation choices: the strobed register port and the register addresses.
`include "pdr_defines.vh"
////////////////////////////////////////////////////////////////////////////////
module pdr_bank (
  input  wire       REF_CLK,
  input  wire       SRST,
  input  wire [3:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  input  wire [3:0] CMP_MATCH,
  output wire [7:0] PULSE_OUT_HIGH,
  output wire [7:0] PULSE_OUT_LOW
);
  reg  [7:0] next_data_high_r;
  reg  [7:0] next_data_low_r;
  reg  [7:0] next_enable_high_r;
  reg  [7:0] next_enable_low_r;
  reg  [7:0] trig_sel_r;
  reg  [7:0] rdata_nxt;
  wire [7:0] out_high;
  wire [7:0] out_low;
  wire [3:0] trig;
  wire       high_shared;
  wire       low_shared;
  // per-group trigger selections and triggers
  wire [1:0] sel_grp3;
  wire [1:0] sel_grp2;
  wire [1:0] sel_grp1;
  wire [1:0] sel_grp0;
  wire       trig_grp3;
  wire       trig_grp2;
  wire       trig_grp1;
  wire       trig_grp0;
  // decoded write strobes, one per register
  wire       wr_out_high;
  wire       wr_out_low;
  wire       wr_nxt_high;
  wire       wr_nxt_high_lo;
  wire       wr_nxt_low;
  wire       wr_nxt_low_lo;
  wire       wr_en_high;
  wire       wr_en_low;
  wire       wr_trig_sel;
  // next values of the cpu-side registers
  reg  [7:0] next_data_high_nxt;
  reg  [7:0] next_data_low_nxt;
  reg  [7:0] next_enable_high_nxt;
  reg  [7:0] next_enable_low_nxt;
  reg  [7:0] trig_sel_nxt;

  // write strobe of one register offset
  function hit;
    input [3:0] a;
    input [3:0] ofs;
    input       wr;
    begin
      hit = wr && (a == ofs);
    end
  endfunction

  // a pair of groups shares a trigger when both select the same channel
  function same_trig;
    input [1:0] sel_a;
    input [1:0] sel_b;
    begin
      same_trig = (sel_a == sel_b);
    end
  endfunction

  // next value of a next-data register under the byte or the nibble views;
  // wr_full and wr_low decode different offsets and never come together
  function [7:0] nxt_data_upd;
    input [7:0] cur;
    input [7:0] wdata;
    input       shared;
    input       wr_full;
    input       wr_low;
    begin
      nxt_data_upd = cur;
      if (wr_full) begin
        if (shared) begin
          nxt_data_upd = wdata;
        end else begin
          // upper nibble view: low positions are fill only
          nxt_data_upd[7:4] = wdata[7:4];
        end
      end
      // the lower nibble view exists only while the pair is split
      if (wr_low && !shared) begin
        nxt_data_upd[3:0] = wdata[3:0];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // trigger selection per group
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_trig
      pdr_trig_sel u_sel (
        .cmp_match (CMP_MATCH),
        .sel       (trig_sel_r[2*g+1:2*g]),
        .trig      (trig[g])
      );
    end
  endgenerate

  // grp3 and grp2 drive the high byte, grp1 and grp0 the low byte
  assign sel_grp3  = trig_sel_r[`PDR_SEL_G3_HI:`PDR_SEL_G3_LO];
  assign sel_grp2  = trig_sel_r[`PDR_SEL_G2_HI:`PDR_SEL_G2_LO];
  assign sel_grp1  = trig_sel_r[`PDR_SEL_G1_HI:`PDR_SEL_G1_LO];
  assign sel_grp0  = trig_sel_r[`PDR_SEL_G0_HI:`PDR_SEL_G0_LO];
  assign trig_grp3 = trig[3];
  assign trig_grp2 = trig[2];
  assign trig_grp1 = trig[1];
  assign trig_grp0 = trig[0];

  // groups sharing a trigger see one full byte, otherwise two nibbles
  assign high_shared = same_trig(sel_grp3, sel_grp2);
  assign low_shared  = same_trig(sel_grp1, sel_grp0);

  ////////////////////////////////////////////////////////////////////////////
  // output data bytes
  pdr_out_byte u_out_high (
    .clk       (REF_CLK),
    .srst      (SRST),
    .enable    (next_enable_high_r),
    .next_data (next_data_high_r),
    .trig_hi   (trig_grp3),
    .trig_lo   (trig_grp2),
    .wr        (wr_out_high),
    .wdata     (WDATA),
    .data_r    (out_high)
  );
  pdr_out_byte u_out_low (
    .clk       (REF_CLK),
    .srst      (SRST),
    .enable    (next_enable_low_r),
    .next_data (next_data_low_r),
    .trig_hi   (trig_grp1),
    .trig_lo   (trig_grp0),
    .wr        (wr_out_low),
    .wdata     (WDATA),
    .data_r    (out_low)
  );
  // pins follow the output registers directly, with no extra stage
  assign PULSE_OUT_HIGH = out_high;
  assign PULSE_OUT_LOW  = out_low;

  ////////////////////////////////////////////////////////////////////////////
  // write strobe decode, one per register
  assign wr_out_high    = hit(ADDR, `PDR_OFS_OUT_HIGH, WR);
  assign wr_out_low     = hit(ADDR, `PDR_OFS_OUT_LOW, WR);
  assign wr_nxt_high    = hit(ADDR, `PDR_OFS_NXT_HIGH, WR);
  assign wr_nxt_high_lo = hit(ADDR, `PDR_OFS_NXT_HIGH_LO, WR);
  assign wr_nxt_low     = hit(ADDR, `PDR_OFS_NXT_LOW, WR);
  assign wr_nxt_low_lo  = hit(ADDR, `PDR_OFS_NXT_LOW_LO, WR);
  assign wr_en_high     = hit(ADDR, `PDR_OFS_EN_HIGH, WR);
  assign wr_en_low      = hit(ADDR, `PDR_OFS_EN_LOW, WR);
  assign wr_trig_sel    = hit(ADDR, `PDR_OFS_TRIG_SEL, WR);

  ////////////////////////////////////////////////////////////////////////////
  // next values; a write to a nibble offset in byte view changes nothing
  always @* begin
    next_data_high_nxt = nxt_data_upd(next_data_high_r, WDATA,
      high_shared, wr_nxt_high, wr_nxt_high_lo);
  end

  always @* begin
    next_data_low_nxt = nxt_data_upd(next_data_low_r, WDATA,
      low_shared, wr_nxt_low, wr_nxt_low_lo);
  end

  always @* begin
    next_enable_high_nxt = next_enable_high_r;
    if (wr_en_high) begin
      next_enable_high_nxt = WDATA;
    end
  end

  always @* begin
    next_enable_low_nxt = next_enable_low_r;
    if (wr_en_low) begin
      next_enable_low_nxt = WDATA;
    end
  end

  always @* begin
    trig_sel_nxt = trig_sel_r;
    if (wr_trig_sel) begin
      trig_sel_nxt = WDATA;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu-side registers; enables reset cleared, so every output bit starts
  // under cpu control and no trigger can disturb it before software is ready
  always @(posedge REF_CLK) begin
    if (SRST) begin
      next_data_high_r <= `PDR_DATA_RST;
    end else begin
      next_data_high_r <= next_data_high_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (SRST) begin
      next_data_low_r <= `PDR_DATA_RST;
    end else begin
      next_data_low_r <= next_data_low_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (SRST) begin
      next_enable_high_r <= `PDR_EN_RST;
    end else begin
      next_enable_high_r <= next_enable_high_nxt;
    end
  end

  always @(posedge REF_CLK) begin
    if (SRST) begin
      next_enable_low_r <= `PDR_EN_RST;
    end else begin
      next_enable_low_r <= next_enable_low_nxt;
    end
  end

  // all ones at reset: both pairs select channel 3 and start in byte view
  always @(posedge REF_CLK) begin
    if (SRST) begin
      trig_sel_r <= `PDR_TRIG_SEL_RST;
    end else begin
      trig_sel_r <= trig_sel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux; nibble offsets read as unmapped while the byte view is active
  always @* begin
    rdata_nxt = `PDR_UNMAPPED_RD;
    case (ADDR)
      `PDR_OFS_OUT_HIGH: rdata_nxt = out_high;
      `PDR_OFS_OUT_LOW:  rdata_nxt = out_low;
      `PDR_OFS_NXT_HIGH: begin
        if (high_shared) begin
          rdata_nxt = next_data_high_r;
        end else begin
          rdata_nxt = {next_data_high_r[7:4], `PDR_NIB_FILL};
        end
      end
      `PDR_OFS_NXT_HIGH_LO: begin
        if (!high_shared) begin
          rdata_nxt = {`PDR_NIB_FILL, next_data_high_r[3:0]};
        end
      end
      `PDR_OFS_NXT_LOW: begin
        if (low_shared) begin
          rdata_nxt = next_data_low_r;
        end else begin
          rdata_nxt = {next_data_low_r[7:4], `PDR_NIB_FILL};
        end
      end
      `PDR_OFS_NXT_LOW_LO: begin
        if (!low_shared) begin
          rdata_nxt = {`PDR_NIB_FILL, next_data_low_r[3:0]};
        end
      end
      `PDR_OFS_EN_HIGH:  rdata_nxt = next_enable_high_r;
      `PDR_OFS_EN_LOW:   rdata_nxt = next_enable_low_r;
      `PDR_OFS_TRIG_SEL: rdata_nxt = trig_sel_r;
      default:           rdata_nxt = `PDR_UNMAPPED_RD;
    endcase
  end

  // read data hold their value until the next read strobe
  always @(posedge REF_CLK) begin
    if (SRST) begin
      RDATA <= `PDR_UNMAPPED_RD;
    end else if (RD) begin
      RDATA <= rdata_nxt;
    end
  end
endmodule

// ---- verification/pdr_bank_sva.sv ----
// port-level checker of the pulse data register bank
module pdr_bank_sva (
  input wire logic       REF_CLK,
  input wire logic       SRST,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic [3:0] CMP_MATCH,
  input wire logic [7:0] PULSE_OUT_HIGH,
  input wire logic [7:0] PULSE_OUT_LOW
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sel_r;
  wire        sh = sel_r[7:6] != sel_r[5:4];
  wire        sl = sel_r[3:2] != sel_r[1:0];
  wire        q  = !WR && CMP_MATCH == 4'h0;
  // shadow of the trigger selection, so the view in force is known
  always_ff @(posedge REF_CLK)
    if (SRST) sel_r <= 8'hff;
    else if (WR && ADDR == 4'h8) sel_r <= WDATA;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  a_hold_high: assert property (q |=> $stable(PULSE_OUT_HIGH))
    else $error("high pins moved without cause");
  a_hold_low: assert property (q |=> $stable(PULSE_OUT_LOW))
    else $error("low pins moved without cause");
  a_rd_hold: assert property (!RD |=> $stable(RDATA))
    else $error("read data moved without a read");
  a_unmapped_rd: assert property (RD && ADDR > 4'h8 |=> RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_high_fill: assert property (RD && ADDR == 4'h3 |=> RDATA[7:4] == {4{sh}})
    else $error("high lower view fill wrong");
  a_high_top: assert property (RD && ADDR == 4'h2 && sh |=> RDATA[3:0] == 4'hf)
    else $error("high upper view fill wrong");
  a_low_fill: assert property (RD && ADDR == 4'h5 |=> RDATA[7:4] == {4{sl}})
    else $error("low lower view fill wrong");
  a_rst_clear: assert property (disable iff (1'b0) SRST |=>
    PULSE_OUT_HIGH == 8'h00 && PULSE_OUT_LOW == 8'h00 && RDATA == 8'h00)
    else $error("reset left a value");
  cover property (RD && ADDR == 4'h3 && sh);
  cover property (RD && ADDR == 4'h5 && sl);
  cover property (CMP_MATCH != 4'h0 ##1 $changed(PULSE_OUT_LOW));
endmodule
bind pdr_bank pdr_bank_sva u_pdr_bank_sva (.REF_CLK(REF_CLK), .SRST(SRST),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .CMP_MATCH(CMP_MATCH), .PULSE_OUT_HIGH(PULSE_OUT_HIGH),
  .PULSE_OUT_LOW(PULSE_OUT_LOW));

// ---- verification/pdr_timer_model.sv ----
// timer stand-in: one compare-match pulse after a chosen delay
module pdr_timer_model (
  input  wire logic       clk,
  input  wire logic       fire,
  input  wire logic [1:0] ch,
  input  wire logic [1:0] dly,
  output logic      [3:0] cmp
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -1;
  always @(posedge clk) begin
    cmp <= 4'h0;
    if (fire) cnt <= dly;
    else if (cnt > 0) cnt <= cnt - 1;
    else if (cnt == 0) begin
      cmp <= 4'h1 << ch;
      cnt <= -1;
    end
  end
endmodule

// ---- verification/test_pdr_bank.sv ----
// self-checking bench: reference model of the bank against the design
module test_pdr_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic        REF_CLK, SRST, WR, RD, fire;
  logic [3:0]  ADDR, CMP_MATCH;
  logic [7:0]  WDATA, RDATA, PULSE_OUT_HIGH, PULSE_OUT_LOW, sel;
  logic [1:0]  ch, dly;
  logic [7:0]  outd[2], nd[2], en[2];
  logic [31:0] op;
  int          failures, checks, i, seed = 32131;
  pdr_bank u_pdr_bank (.REF_CLK(REF_CLK), .SRST(SRST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CMP_MATCH(CMP_MATCH),
    .PULSE_OUT_HIGH(PULSE_OUT_HIGH), .PULSE_OUT_LOW(PULSE_OUT_LOW));
  pdr_timer_model u_pdr_timer_model (.clk(REF_CLK), .fire(fire), .ch(ch),
    .dly(dly), .cmp(CMP_MATCH));
  initial begin
    REF_CLK = 0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  function automatic bit sp(int k); // pair split when its groups differ
    return sel[7-4*k -: 2] != sel[5-4*k -: 2];
  endfunction
  function automatic logic [7:0] mrd(logic [3:0] a);
    case (a)
      0, 1: return outd[a];
      2, 4: return sp(a[2]) ? {nd[a[2]][7:4], 4'hf} : nd[a[2]];
      3, 5: return sp(a[2]) ? {4'hf, nd[a[2]][3:0]} : 8'h00;
      6, 7: return en[a - 4'h6];
      8: return sel;
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge REF_CLK);
    WR <= 1;
    ADDR <= a;
    WDATA <= d;
    @(posedge REF_CLK);
    WR <= 0;
    case (a)
      0, 1: outd[a] = outd[a] & en[a] | d & ~en[a];
      2, 4: nd[a[2]] = sp(a[2]) ? {d[7:4], nd[a[2]][3:0]} : d;
      3, 5: if (sp(a[2])) nd[a[2]][3:0] = d[3:0];
      6, 7: en[a - 4'h6] = d;
      8: sel = d;
    endcase
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge REF_CLK);
    RD <= 1;
    ADDR <= a;
    @(posedge REF_CLK);
    RD <= 0;
    @(negedge REF_CLK);
    chk("read", RDATA, mrd(a));
  endtask
  task automatic trig(logic [1:0] c, logic [1:0] d);
    logic [7:0] m;
    @(posedge REF_CLK);
    fire <= 1;
    ch <= c;
    dly <= d;
    @(posedge REF_CLK);
    fire <= 0;
    repeat (d + 3) @(posedge REF_CLK);
    for (int k = 0; k < 4; k++)
      if (sel[7-2*k -: 2] == c) begin
        m = (k[0] ? 8'h0f : 8'hf0) & en[k/2];
        outd[k/2] = outd[k/2] & ~m | nd[k/2] & m;
      end
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    give_verdict;
  end
  initial begin
    SRST = 1;
    WR = 0;
    RD = 0;
    fire = 0;
    ADDR = 0;
    WDATA = 0;
    ch = 0;
    dly = 0;
    outd = '{default: 8'h00};
    nd = '{default: 8'h00};
    en = '{default: 8'h00};
    sel = 8'hff;
    repeat (20) @(posedge REF_CLK);
    SRST <= 0;
    for (i = 0; i < 16; i++) rd(4'(i));
    for (i = 0; i < 400; i++) begin
      op = $random(seed);
      if (op[0]) trig(op[2:1], op[4:3]);
      else wr(op[11:8], op[23:16]);
      @(negedge REF_CLK);
      chk("high pins", PULSE_OUT_HIGH, outd[0]);
      chk("low pins", PULSE_OUT_LOW, outd[1]);
      rd(op[15:12]);
      if (i == 200) begin
        @(posedge REF_CLK);
        SRST <= 1;
        repeat (3) @(posedge REF_CLK);
        SRST <= 0;
        outd = '{default: 8'h00};
        nd = '{default: 8'h00};
        en = '{default: 8'h00};
        sel = 8'hff;
      end
    end
    give_verdict;
  end
endmodule
